// file: rtl/cbd_target.sv
// Device end: collects a command block, decodes and checks it, hands
// good commands to the command engine and limits returned data.
// Assumes the link and the engine run on sys_clk.
`default_nettype none

module cbd_target (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Link to the initiator
  cbd_link_if.target lnk,
  // Decoded command to the engine
  output logic usr_exec,
  output logic [7:0] usr_opcode,
  output logic [4:0] usr_cmd_code,
  output logic [2:0] usr_lun,
  output logic [31:0] usr_lba,
  output logic [31:0] usr_len,
  output logic [31:0] usr_blocks,
  output logic usr_link,
  output logic usr_flag,
  output logic usr_reject,
  // Returned data and completion from the engine
  input wire logic usr_din_valid,
  input wire logic [7:0] usr_din_data,
  input wire logic [31:0] usr_din_avail,
  input wire logic usr_done,
  output logic usr_din_ready
);

  // -----------------------------------------------------------------------
  // State
  // -----------------------------------------------------------------------
  cbd_pkg::cbd_tg_state_t state_reg, state_next;
  logic [7:0] cdb_reg [cbd_pkg::CDB_MAX];
  logic [3:0] cnt_reg;
  logic [3:0] nb_reg;
  logic [31:0] din_cnt_reg;
  logic [31:0] alloc_reg;
  logic check_reg;

  // Decode wires
  logic [2:0] grp;
  logic [3:0] exp_len;
  logic [7:0] ctl;
  logic bad;
  logic [31:0] lba;
  logic [31:0] len;
  logic [31:0] lim;
  logic take;
  logic fwd;

  assign take = lnk.cmd_valid && lnk.cmd_ready;

  // -----------------------------------------------------------------------
  // Decode of the held block
  // -----------------------------------------------------------------------
  // Group code picks the length; unknown groups give no length
  always_comb begin
    grp = cdb_reg[0][cbd_pkg::GRP_MSB:cbd_pkg::GRP_LSB];
    unique case (grp)
      3'h0: exp_len = cbd_pkg::LEN_SIX;
      3'h1, 3'h2: exp_len = cbd_pkg::LEN_TEN;
      3'h5: exp_len = cbd_pkg::LEN_TWELVE;
      default: exp_len = cbd_pkg::LEN_NONE;
    endcase
  end

  // Control byte is always the final byte received
  assign ctl = cdb_reg[nb_reg - 4'h1];

  // Any nonzero reserved content or reserved code rejects the block
  always_comb begin
    bad = 1'b0;
    if (exp_len == cbd_pkg::LEN_NONE) begin
      bad = 1'b1;
    end
    if (nb_reg != exp_len) begin
      bad = 1'b1;
    end
    if (ctl[cbd_pkg::CTL_RSV_MSB:cbd_pkg::CTL_RSV_LSB] != 4'h0) begin
      bad = 1'b1;
    end
    if (ctl[cbd_pkg::CTL_FLAG] && !ctl[cbd_pkg::CTL_LINK]) begin
      bad = 1'b1;
    end
    if (exp_len != cbd_pkg::LEN_SIX && cdb_reg[1][4:0] != 5'h00) begin
      bad = 1'b1;
    end
    if (exp_len == cbd_pkg::LEN_TEN &&
        cdb_reg[cbd_pkg::RSV_BYTE_TEN] != 8'h00) begin
      bad = 1'b1;
    end
    if (exp_len == cbd_pkg::LEN_TWELVE &&
        cdb_reg[cbd_pkg::RSV_BYTE_TWELVE] != 8'h00) begin
      bad = 1'b1;
    end
  end

  // Address and length fields per layout
  always_comb begin
    if (exp_len == cbd_pkg::LEN_SIX) begin
      // Short form: 21-bit address, one length byte
      lba = {11'h000, cdb_reg[1][4:0], cdb_reg[2], cdb_reg[3]};
      len = {24'h000000, cdb_reg[4]};
    end else if (exp_len == cbd_pkg::LEN_TEN) begin
      lba = {cdb_reg[2], cdb_reg[3], cdb_reg[4], cdb_reg[5]};
      len = {16'h0000, cdb_reg[7], cdb_reg[8]};
    end else begin
      lba = {cdb_reg[2], cdb_reg[3], cdb_reg[4], cdb_reg[5]};
      len = {cdb_reg[6], cdb_reg[7], cdb_reg[8], cdb_reg[9]};
    end
  end

  // -----------------------------------------------------------------------
  // Sequencer
  // -----------------------------------------------------------------------
  // Collect until the last byte or a full buffer, check, run, report
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      cbd_pkg::TG_GET: begin
        if (take && (lnk.cmd_last || cnt_reg == 4'hb)) begin
          state_next = cbd_pkg::TG_CHK;
        end
      end
      cbd_pkg::TG_CHK: begin
        // A bad block never enters the run state
        state_next = bad ? cbd_pkg::TG_STS : cbd_pkg::TG_RUN;
      end
      cbd_pkg::TG_RUN: begin
        if (usr_done) begin
          state_next = cbd_pkg::TG_STS;
        end
      end
      cbd_pkg::TG_STS: state_next = cbd_pkg::TG_GET;
    endcase
  end

  // State register
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= cbd_pkg::TG_GET;
    end else begin
      state_reg <= state_next;
    end
  end

  // Byte capture; count restarts for each block
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= 4'h0;
      nb_reg <= 4'h0;
      for (int i = 0; i < cbd_pkg::CDB_MAX; i++) begin
        cdb_reg[i] <= 8'h00;
      end
    end else if (state_reg == cbd_pkg::TG_GET && take) begin
      cdb_reg[cnt_reg] <= lnk.cmd_byte;
      cnt_reg <= cnt_reg + 4'h1;
      nb_reg <= cnt_reg + 4'h1;
    end else if (state_reg != cbd_pkg::TG_GET) begin
      cnt_reg <= 4'h0;
    end
  end

  // Ready only while collecting; held low from the last byte on
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      lnk.cmd_ready <= 1'b0;
    end else begin
      lnk.cmd_ready <= (state_next == cbd_pkg::TG_GET);
    end
  end

  // -----------------------------------------------------------------------
  // Hand-over to the engine
  // -----------------------------------------------------------------------
  // Fields are latched at the check; exec and reject are one-cycle pulses.
  // Every accepted opcode goes to the engine, which owns command support.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      usr_exec <= 1'b0;
      usr_reject <= 1'b0;
      usr_opcode <= 8'h00;
      usr_cmd_code <= 5'h00;
      usr_lun <= 3'h0;
      usr_lba <= 32'h0000_0000;
      usr_len <= 32'h0000_0000;
      usr_blocks <= 32'h0000_0000;
      usr_link <= 1'b0;
      usr_flag <= 1'b0;
      check_reg <= 1'b0;
      alloc_reg <= 32'h0000_0000;
    end else if (state_reg == cbd_pkg::TG_CHK) begin
      usr_exec <= !bad;
      usr_reject <= bad;
      check_reg <= bad;
      usr_opcode <= cdb_reg[0];
      usr_cmd_code <= cdb_reg[0][4:0];
      // Identify message wins over the in-block unit number
      usr_lun <= lnk.ident_valid ? lnk.ident_lun : cdb_reg[1][7:5];
      // Address passed on as received; numbering starts at block zero
      usr_lba <= lba;
      usr_len <= len;
      alloc_reg <= len;
      // One length byte of zero stands for 256 blocks; wider zero is none
      if (exp_len == cbd_pkg::LEN_SIX && len == 32'h0000_0000) begin
        usr_blocks <= cbd_pkg::ONE_BYTE_ZERO_BLOCKS;
      end else begin
        usr_blocks <= len;
      end
      usr_link <= ctl[cbd_pkg::CTL_LINK];
      usr_flag <= ctl[cbd_pkg::CTL_FLAG];
    end else begin
      usr_exec <= 1'b0;
      usr_reject <= 1'b0;
    end
  end

  // -----------------------------------------------------------------------
  // Returned data
  // -----------------------------------------------------------------------
  // Limit is the smaller of allocation and what the engine has
  assign lim = (alloc_reg < usr_din_avail) ? alloc_reg : usr_din_avail;
  assign fwd = usr_din_valid && usr_din_ready && (din_cnt_reg < lim);

  // Bytes past the limit are taken and dropped so the engine never stalls
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      din_cnt_reg <= 32'h0000_0000;
      lnk.din_valid <= 1'b0;
      lnk.din_byte <= 8'h00;
      usr_din_ready <= 1'b0;
    end else begin
      usr_din_ready <= (state_next == cbd_pkg::TG_RUN);
      lnk.din_valid <= fwd;
      if (fwd) begin
        lnk.din_byte <= usr_din_data;
        din_cnt_reg <= din_cnt_reg + 32'h0000_0001;
      end else if (state_reg == cbd_pkg::TG_GET) begin
        din_cnt_reg <= 32'h0000_0000;
      end
    end
  end

  // -----------------------------------------------------------------------
  // Outcome
  // -----------------------------------------------------------------------
  // One pulse per block; check marks an illegal request
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      lnk.sts_valid <= 1'b0;
      lnk.sts_check <= 1'b0;
    end else begin
      lnk.sts_valid <= (state_reg == cbd_pkg::TG_STS);
      if (state_reg == cbd_pkg::TG_STS) begin
        lnk.sts_check <= check_reg;
      end
    end
  end

endmodule

`default_nettype wire

// file: rtl/cbd_pkg.sv
// Shared constants for the command block decoder and its initiator end.
// Assumes one clock domain for both ends; software reaches the initiator
// end over APB with 32-bit data.
`default_nettype none

package cbd_pkg;
  // ---------------------------------------------------------------------
  // Command block structure
  // ---------------------------------------------------------------------
  localparam int GRP_MSB = 7;
  localparam int GRP_LSB = 5;
  localparam int CTL_LINK = 0;
  localparam int CTL_FLAG = 1;
  localparam int CTL_RSV_MSB = 5;
  localparam int CTL_RSV_LSB = 2;
  localparam int CDB_MAX = 12;
  localparam logic [3:0] LEN_SIX = 4'h6;
  localparam logic [3:0] LEN_TEN = 4'ha;
  localparam logic [3:0] LEN_TWELVE = 4'hc;
  localparam logic [3:0] LEN_NONE = 4'h0;
  localparam logic [3:0] RSV_BYTE_TEN = 4'h6;
  localparam logic [3:0] RSV_BYTE_TWELVE = 4'ha;
  localparam logic [31:0] ONE_BYTE_ZERO_BLOCKS = 32'h0000_0100;

  // ---------------------------------------------------------------------
  // Initiator register map (byte addresses)
  // ---------------------------------------------------------------------
  localparam logic [7:0] REG_CDB0 = 8'h00;
  localparam logic [7:0] REG_CDB1 = 8'h04;
  localparam logic [7:0] REG_CDB2 = 8'h08;
  localparam logic [7:0] REG_CTRL = 8'h0c;
  localparam logic [7:0] REG_STAT = 8'h10;
  localparam logic [7:0] REG_DIN = 8'h14;
  localparam int CTRL_GO = 0;
  localparam int CTRL_IDENT = 1;
  localparam int CTRL_LUN_LSB = 4;
  localparam int CTRL_VLEN_LSB = 8;
  localparam int STAT_BUSY = 0;
  localparam int STAT_DONE = 1;
  localparam int STAT_CHECK = 2;
  localparam int STAT_REFUSED = 3;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;

  // Device end states
  typedef enum logic [1:0] {
    TG_GET = 2'b00,
    TG_CHK = 2'b01,
    TG_RUN = 2'b10,
    TG_STS = 2'b11
  } cbd_tg_state_t;

  // Initiator end states
  typedef enum logic [1:0] {
    IN_IDLE = 2'b00,
    IN_SEND = 2'b01,
    IN_WAIT = 2'b10
  } cbd_in_state_t;
endpackage

`default_nettype wire

// file: rtl/cbd_link_if.sv
// Link between initiator end and device end of the command decoder.
// Assumes both ends run on the same clock; the bench joins them.
`default_nettype none

interface cbd_link_if;
  // Command bytes, initiator to device
  logic cmd_valid;
  logic [7:0] cmd_byte;
  logic cmd_last;
  logic cmd_ready;
  // Unit selected by an earlier identify message
  logic ident_valid;
  logic [2:0] ident_lun;
  // Returned data and final outcome, device to initiator
  logic din_valid;
  logic [7:0] din_byte;
  logic sts_valid;
  logic sts_check;

  modport target (
    input cmd_valid, cmd_byte, cmd_last, ident_valid, ident_lun,
    output cmd_ready, din_valid, din_byte, sts_valid, sts_check
  );
  modport initiator (
    output cmd_valid, cmd_byte, cmd_last, ident_valid, ident_lun,
    input cmd_ready, din_valid, din_byte, sts_valid, sts_check
  );
endinterface

`default_nettype wire

// file: rtl/cbd_initiator.sv
// Initiator end: software loads a block over APB, this end scrubs the
// reserved fields, sends it with the control byte last and records the
// outcome and returned data. Assumes the link shares sys_clk.
`default_nettype none

module cbd_initiator (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Link to the device
  cbd_link_if.initiator lnk
);

  // -----------------------------------------------------------------------
  // Registers
  // -----------------------------------------------------------------------
  cbd_pkg::cbd_in_state_t state_reg;
  logic [95:0] cdb_reg;
  logic [31:0] ctrl_reg;
  logic [3:0] len_reg;
  logic [3:0] idx_reg;
  logic done_reg, check_reg, refused_reg;
  logic [15:0] din_cnt_reg;
  logic [7:0] din_last_reg;
  logic wr;
  logic go;
  logic [2:0] grp;
  logic [3:0] glen;

  assign wr = psel && penable && pready && pwrite;
  assign go = wr && paddr == cbd_pkg::REG_CTRL && pwdata[cbd_pkg::CTRL_GO]
              && state_reg == cbd_pkg::IN_IDLE;
  assign grp = cdb_reg[cbd_pkg::GRP_MSB:cbd_pkg::GRP_LSB];

  // Length from the group; vendor groups use the programmed length
  always_comb begin
    unique case (grp)
      3'h0: glen = cbd_pkg::LEN_SIX;
      3'h1, 3'h2: glen = cbd_pkg::LEN_TEN;
      3'h5: glen = cbd_pkg::LEN_TWELVE;
      3'h3, 3'h4: glen = cbd_pkg::LEN_NONE;
      default: glen = pwdata[cbd_pkg::CTRL_VLEN_LSB +: 4];
    endcase
  end

  // Byte i of the block with reserved fields forced to zero
  function automatic logic [7:0] scrub(input logic [95:0] cdb,
                                       input logic [3:0] i,
                                       input logic [3:0] n,
                                       input logic ident);
    logic [7:0] b;
    b = cdb[{i, 3'h0} +: 8];
    if (i == 4'h1 && n != cbd_pkg::LEN_SIX) begin
      b[4:0] = 5'h00;
    end
    if (i == 4'h1 && ident) begin
      b[7:5] = 3'h0;
    end
    if ((n == cbd_pkg::LEN_TEN && i == cbd_pkg::RSV_BYTE_TEN) ||
        (n == cbd_pkg::LEN_TWELVE && i == cbd_pkg::RSV_BYTE_TWELVE)) begin
      b = 8'h00;
    end
    if (i == n - 4'h1) begin
      b[cbd_pkg::CTL_RSV_MSB:cbd_pkg::CTL_RSV_LSB] = 4'h0;
    end
    return b;
  endfunction

  // -----------------------------------------------------------------------
  // APB slave: one-cycle access, no wait states
  // -----------------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= cbd_pkg::RST_WORD;
    end else begin
      pready <= psel && !penable;
      pslverr <= 1'b0;
      unique case (paddr)
        cbd_pkg::REG_CDB0: prdata <= cdb_reg[31:0];
        cbd_pkg::REG_CDB1: prdata <= cdb_reg[63:32];
        cbd_pkg::REG_CDB2: prdata <= cdb_reg[95:64];
        cbd_pkg::REG_CTRL: prdata <= ctrl_reg;
        cbd_pkg::REG_STAT: prdata <= {28'h0000000, refused_reg, check_reg,
                                      done_reg,
                                      state_reg != cbd_pkg::IN_IDLE};
        cbd_pkg::REG_DIN: prdata <= {8'h00, din_last_reg, din_cnt_reg};
        default: prdata <= cbd_pkg::RST_WORD;
      endcase
    end
  end

  // Block and control registers; the go bit itself is not stored
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cdb_reg <= 96'h0;
      ctrl_reg <= cbd_pkg::RST_WORD;
    end else if (wr && state_reg == cbd_pkg::IN_IDLE) begin
      if (paddr == cbd_pkg::REG_CDB0) cdb_reg[31:0] <= pwdata;
      if (paddr == cbd_pkg::REG_CDB1) cdb_reg[63:32] <= pwdata;
      if (paddr == cbd_pkg::REG_CDB2) cdb_reg[95:64] <= pwdata;
      if (paddr == cbd_pkg::REG_CTRL) ctrl_reg <= {pwdata[31:1], 1'b0};
    end
  end

  // -----------------------------------------------------------------------
  // Sender and result capture
  // -----------------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= cbd_pkg::IN_IDLE;
      len_reg <= 4'h0;
      idx_reg <= 4'h0;
      lnk.cmd_valid <= 1'b0;
      lnk.cmd_byte <= 8'h00;
      lnk.cmd_last <= 1'b0;
      done_reg <= 1'b0;
      check_reg <= 1'b0;
      refused_reg <= 1'b0;
    end else begin
      unique case (state_reg)
        cbd_pkg::IN_IDLE: begin
          if (go && (glen == cbd_pkg::LEN_NONE)) begin
            // Reserved group is never put on the link
            refused_reg <= 1'b1;
            done_reg <= 1'b1;
            // No stale check outcome from the block before
            check_reg <= 1'b0;
          end else if (go) begin
            refused_reg <= 1'b0;
            done_reg <= 1'b0;
            check_reg <= 1'b0;
            len_reg <= glen;
            idx_reg <= 4'h0;
            lnk.cmd_valid <= 1'b1;
            lnk.cmd_byte <= scrub(cdb_reg, 4'h0, glen,
                                  pwdata[cbd_pkg::CTRL_IDENT]);
            lnk.cmd_last <= (glen == 4'h1);
            state_reg <= cbd_pkg::IN_SEND;
          end
        end
        cbd_pkg::IN_SEND: begin
          if (lnk.cmd_ready && lnk.cmd_last) begin
            lnk.cmd_valid <= 1'b0;
            lnk.cmd_last <= 1'b0;
            state_reg <= cbd_pkg::IN_WAIT;
          end else if (lnk.cmd_ready) begin
            idx_reg <= idx_reg + 4'h1;
            lnk.cmd_byte <= scrub(cdb_reg, idx_reg + 4'h1, len_reg,
                                  ctrl_reg[cbd_pkg::CTRL_IDENT]);
            lnk.cmd_last <= (idx_reg + 4'h2 == len_reg);
          end
        end
        cbd_pkg::IN_WAIT: begin
          if (lnk.sts_valid) begin
            done_reg <= 1'b1;
            check_reg <= lnk.sts_check;
            state_reg <= cbd_pkg::IN_IDLE;
          end
        end
        default: state_reg <= cbd_pkg::IN_IDLE;
      endcase
    end
  end

  // Identify level taken from the control write that sets the go bit
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      lnk.ident_valid <= 1'b0;
      lnk.ident_lun <= 3'h0;
    end else if (go) begin
      lnk.ident_valid <= pwdata[cbd_pkg::CTRL_IDENT];
      lnk.ident_lun <= pwdata[cbd_pkg::CTRL_LUN_LSB +: 3];
    end
  end

  // Returned data count and last byte; count cleared on each new command
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      din_cnt_reg <= 16'h0000;
      din_last_reg <= 8'h00;
    end else if (lnk.din_valid) begin
      din_cnt_reg <= din_cnt_reg + 16'h0001;
      din_last_reg <= lnk.din_byte;
    end else if (go) begin
      din_cnt_reg <= 16'h0000;
    end
  end

endmodule

`default_nettype wire

// file: tb/cbd_link_assertions.sv
// Checker for the command link that joins the two decoder ends.
// Assumes the bench hands it the signals of the one link instance.
`default_nettype none

module cbd_link_assertions (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Command bytes and identify state
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_byte,
  input wire logic cmd_last,
  input wire logic cmd_ready,
  input wire logic ident_valid,
  input wire logic [2:0] ident_lun,
  // Returned data and outcome
  input wire logic din_valid,
  input wire logic [7:0] din_byte,
  input wire logic sts_valid,
  input wire logic sts_check
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  logic take;
  logic [3:0] idx_reg;
  logic [7:0] opc_reg;

  // -----------------------------------------------------------------
  // Position tracking
  // -----------------------------------------------------------------
  assign take = cmd_valid && cmd_ready;

  // Byte index inside the block in flight
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) idx_reg <= 4'h0;
    else if (take) idx_reg <= cmd_last ? 4'h0 : idx_reg + 4'h1;
  end

  // Opcode kept so later bytes can be judged by group
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) opc_reg <= 8'h00;
    else if (take && idx_reg == 4'h0) opc_reg <= cmd_byte;
  end

  // -----------------------------------------------------------------
  // Link properties
  // -----------------------------------------------------------------
  hold_req_a: assert property (cmd_valid && !cmd_ready |=>
    cmd_valid && $stable(cmd_byte) && $stable(cmd_last))
    else $error("command byte changed before it was taken");
  no_rsv_grp_a: assert property (take && idx_reg == 4'h0 |->
    !(cmd_byte[7:5] inside {3'd3, 3'd4}))
    else $error("reserved group sent");
  ctl_rsv_zero_a: assert property (take && cmd_last |->
    cmd_byte[5:2] == 4'h0) else $error("control reserved bits set");
  lun_zero_a: assert property (take && idx_reg == 4'h1 &&
    ident_valid |-> cmd_byte[7:5] == 3'h0) else $error("unit field not zero");
  byte1_rsv_a: assert property (take && idx_reg == 4'h1 &&
    opc_reg[7:5] inside {3'd1, 3'd2, 3'd5} |-> cmd_byte[4:0] == 5'h00)
    else $error("byte one reserved bits set");
  byte6_rsv_a: assert property (take && idx_reg == 4'h6 &&
    opc_reg[7:5] inside {3'd1, 3'd2} |-> cmd_byte == 8'h00)
    else $error("byte six not zero");
  blk_len_a: assert property (take && cmd_last && idx_reg != 4'h0 &&
    opc_reg[7:5] inside {3'd0, 3'd1, 3'd2, 3'd5} |-> idx_reg ==
    (opc_reg[7:5] == 3'd0 ? 4'h5 : opc_reg[7:5] == 3'd5 ? 4'hb : 4'h9))
    else $error("block length does not match group");
  flag_nolink_a: assert property (take && cmd_last &&
    cmd_byte[1:0] == 2'b10 |-> ##3 sts_valid && sts_check)
    else $error("flag without link not refused");
  vendor_rej_a: assert property (take && cmd_last && idx_reg != 4'h0
    && opc_reg[7:6] == 2'b11 |-> ##3 sts_valid && sts_check)
    else $error("vendor group not refused");
endmodule

`default_nettype wire

// file: tb/test_command_block_decoder.sv
// Bench for the decoder: initiator end driven over APB, device end
// served by a small engine stand-in. Assumes one shared sys_clk.
`default_nettype none

module test_command_block_decoder;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr, usr_din_data, usr_opcode;
  logic [31:0] pwdata, prdata, usr_din_avail, usr_lba, usr_len, q;
  logic [31:0] usr_blocks;
  logic usr_exec, usr_reject, usr_link, usr_din_valid, usr_done;
  logic usr_flag, usr_din_ready;
  logic [4:0] usr_cmd_code;
  logic [2:0] usr_lun;
  int failures, check_count;
  cbd_link_if link();

  // -----------------------------------------------------------------
  // Both ends and the link checker
  // -----------------------------------------------------------------
  cbd_initiator cbd_initiator_i (.sys_clk(sys_clk), .rst_n(rst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .lnk(link));
  cbd_target cbd_target_i (.sys_clk(sys_clk), .rst_n(rst_n), .lnk(link),
    .usr_exec(usr_exec), .usr_opcode(usr_opcode),
    .usr_cmd_code(usr_cmd_code),
    .usr_lun(usr_lun), .usr_lba(usr_lba), .usr_len(usr_len),
    .usr_blocks(usr_blocks), .usr_link(usr_link), .usr_flag(usr_flag),
    .usr_reject(usr_reject), .usr_din_valid(usr_din_valid),
    .usr_din_data(usr_din_data), .usr_din_avail(usr_din_avail),
    .usr_done(usr_done), .usr_din_ready(usr_din_ready));
  cbd_link_assertions cbd_link_assertions_i (.sys_clk(sys_clk),
    .rst_n(rst_n), .cmd_valid(link.cmd_valid), .cmd_byte(link.cmd_byte),
    .cmd_last(link.cmd_last), .cmd_ready(link.cmd_ready),
    .ident_valid(link.ident_valid), .ident_lun(link.ident_lun),
    .din_valid(link.din_valid), .din_byte(link.din_byte),
    .sts_valid(link.sts_valid), .sts_check(link.sts_check));

  // Free-running 100 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // -----------------------------------------------------------------
  // Tasks
  // -----------------------------------------------------------------
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      failures++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask

  // One APB transfer, then an idle cycle so strobes never reassert
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask

  // Load and start a block, play the engine, then read the outcome
  task run(input logic [31:0] c0, c1, c2, ctl, input int oc, nb,
           input logic [31:0] av, input logic [15:0] cnt,
           input logic [2:0] st);
    int k;
    int got;
    usr_din_avail <= av;
    apb(1'b1, cbd_pkg::REG_CDB0, c0);
    apb(1'b1, cbd_pkg::REG_CDB1, c1);
    apb(1'b1, cbd_pkg::REG_CDB2, c2);
    apb(1'b1, cbd_pkg::REG_CTRL, ctl);
    got = 0;
    for (k = 0; k < 40 && got == 0; k++) begin
      @(posedge sys_clk);
      if (usr_exec === 1'b1) got = 1;
      else if (usr_reject === 1'b1) got = 2;
    end
    chk("outcome", 32'(oc), 32'(got));
    if (got == 1) begin
      chk("din ready", 32'h1, 32'(usr_din_ready));
      for (k = 0; k < nb; k++) begin
        usr_din_valid <= 1'b1;
        usr_din_data <= 8'ha0 + 8'(k);
        @(posedge sys_clk);
      end
      usr_din_valid <= 1'b0;
      usr_done <= 1'b1;
      @(posedge sys_clk);
      usr_done <= 1'b0;
    end
    // Poll bounded: done set and busy clear
    for (k = 0; k < 60; k++) begin
      apb(1'b0, cbd_pkg::REG_STAT, 32'h0);
      if (q[1:0] == 2'b10) break;
    end
    chk("status", 32'(st), 32'(q[3:1]));
    apb(1'b0, cbd_pkg::REG_DIN, 32'h0);
    if (oc == 1) chk("din count", 32'(cnt), 32'(q[15:0]));
  endtask

  task final_report;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // Watchdog: the whole sequence needs a few hundred cycles
  initial begin
    #200us;
    failures++;
    final_report;
  end

  // -----------------------------------------------------------------
  // Test sequence
  // -----------------------------------------------------------------
  initial begin
    failures = 0;
    check_count = 0;
    {rst_n, psel, penable, pwrite, usr_din_valid, usr_done} = 6'h00;
    {paddr, usr_din_data, pwdata, usr_din_avail} = 80'h0;
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    apb(1'b0, cbd_pkg::REG_CTRL, 32'h0);
    chk("ctrl reset", cbd_pkg::RST_WORD, q);
    apb(1'b0, 8'h3c, 32'h0);
    chk("unmapped", 32'h0, q);
    chk("slverr", 32'h0, 32'(pslverr));
    // Six-byte, one-byte length zero
    run(32'hcdab5f08, 32'h0, 32'h0, 32'h1, 1, 0, 0, 0, 3'b001);
    chk("lba6", 32'h001fabcd, usr_lba);
    chk("blocks6", 32'h100, usr_blocks);
    chk("lun6", 32'h2, 32'(usr_lun));
    chk("code6", 32'h8, 32'(usr_cmd_code));
    chk("opcode6", 32'h8, 32'(usr_opcode));
    // Ten-byte, identify lun 5, reserved bytes loaded dirty, link set
    run(32'h34123f28, 32'h00ff7856, 32'h105, 32'h53,
        1, 6, 3, 3, 3'b001);
    chk("lba10", 32'h12345678, usr_lba);
    chk("len10", 32'h5, usr_len);
    chk("blocks10", 32'h5, usr_blocks);
    chk("link10", 32'h1, 32'(usr_link));
    chk("lun10", 32'h5, 32'(usr_lun));
    // Twelve-byte, zero lengths: nothing returned, no error
    run(32'ha8, 32'h1000, 32'h0, 32'h1, 1, 2, 4, 0, 3'b001);
    chk("lba12", 32'h10, usr_lba);
    chk("blocks12", 32'h0, usr_blocks);
    // Group two and scrubbed control reserved bits
    run(32'h55, 32'h0, 32'h300, 32'h1, 1, 0, 0, 0, 3'b001);
    chk("flag2", 32'h1, 32'(usr_flag));
    run(32'h1, 32'h3c00, 32'h0, 32'h1, 1, 0, 0, 0, 3'b001);
    // Flag without link, reserved and vendor groups
    run(32'ha, 32'h201, 32'h0, 32'h1, 2, 0, 0, 0, 3'b011);
    run(32'h60, 32'h0, 32'h0, 32'h1, 0, 0, 0, 0, 3'b101);
    run(32'h80, 32'h0, 32'h0, 32'h1, 0, 0, 0, 0, 3'b101);
    run(32'hc0, 32'h0, 32'h0, 32'h601, 2, 0, 0, 0, 3'b011);
    run(32'he0, 32'h0, 32'h0, 32'h601, 2, 0, 0, 0, 3'b011);
    final_report;
  end
endmodule

`default_nettype wire
